//--- logic/ccrs_pkg.sv
// Constants and types for the clock control register set
package ccrs_pkg;
  // Register addresses on the plain register port
  localparam logic [1:0] ADDR_TRIM = 2'h0;
  localparam logic [1:0] ADDR_DIV = 2'h1;
  localparam logic [1:0] ADDR_CMD = 2'h2;
  localparam logic [1:0] ADDR_SEL = 2'h3;
  // Field positions
  localparam int UNLOCK_BIT = 7;
  localparam int READY_BIT = 4;
  localparam int CLOCK_PIN_OUTPUT_BIT_BIT = 6;
  // Reset values and largest legal code of the division field
  localparam logic [3:0] DIV_RST_PLAIN = 4'h0;
  localparam logic [3:0] DIV_RST_BY8 = 4'h3;
  localparam logic [3:0] DIV_MAX_CODE = 4'h8;
  // Unlock window in cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // Command codes
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_DISABLE = 4'h1,
    CMD_ENABLE = 4'h2,
    CMD_REQUEST = 4'h3,
    CMD_SWITCH = 4'h4,
    CMD_RECOVER = 4'h5,
    CMD_WDOG_AUTO = 4'h6,
    CMD_CLK_OUT = 4'h7
  } ccrs_cmd_e;
endpackage : ccrs_pkg

//--- logic/ccrs_unlock.sv
// Timed unlock bit with a fixed four-cycle window
`timescale 1ns/1ps
module ccrs_unlock
  import ccrs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic arm,
  input wire logic consume,
  // Status
  output logic open_ff
);
  logic [2:0] cnt_ff;

  // Rearming inside the window neither extends nor clears it
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      open_ff <= 1'b0;
      cnt_ff <= 3'h0;
    end
    else if (open_ff)
    begin
      if (consume || cnt_ff == UNLOCK_CYCLES - 3'h1)
      begin
        open_ff <= 1'b0;
        cnt_ff <= 3'h0;
      end
      else
      begin
        cnt_ff <= cnt_ff + 3'h1;
      end
    end
    else if (arm)
    begin
      open_ff <= 1'b1;
      cnt_ff <= 3'h0;
    end
  end

  // Window closes by the fourth cycle
  unlock_window_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(open_ff) |-> ##[1:4] !open_ff)
    else $error("unlock window too long");
endmodule : ccrs_unlock

//--- logic/ccrs_top.sv
// Clock control register set: trim, divider, command and selection registers
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ccrs_top
  import ccrs_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = 8'h80
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_ff,
  // Fuses, static from pins
  input wire logic div_eight_fuse,
  input wire logic clock_pin_output_fuse,
  input wire logic [1:0] startup_fuses,
  input wire logic [3:0] source_select_fuses,
  // Clock switch logic
  input wire logic clk_avail_pin,
  input wire logic [3:0] current_source,
  output logic [3:0] cmd_code_ff,
  output logic cmd_valid_ff,
  output logic [3:0] cmd_source_ff,
  output logic [1:0] cmd_startup_ff,
  output logic cmd_clk_out_ff,
  output logic wdog_auto_ff,
  // Oscillator and divided clock enable
  output logic trim_range_select_ff,
  output logic [6:0] trim_fine_value_ff,
  output logic [3:0] division_select_ff,
  output logic sys_clk_en_ff
);
  logic [7:0] rc_osc_trim_ff;
  logic source_ready_flag_ff;
  logic [3:0] clock_command_code_ff;
  logic clock_pin_output_bit_ff;
  logic [1:0] startup_time_code_ff;
  logic [3:0] source_code_field_ff;
  logic div_open;
  logic cmd_open;
  logic avail_s1_ff;
  logic avail_s2_ff;
  logic [3:0] fuse_div_s1_ff;
  logic [3:0] fuse_div_s2_ff;
  logic [3:0] src_fuse_s1_ff;
  logic [3:0] src_fuse_s2_ff;
  logic [3:0] div_target_ff;
  logic [7:0] div_cnt_ff;
  logic reset_seen_ff;
  logic wr_div;
  logic wr_cmd;
  logic [7:0] nxt_rdata;
  logic [7:0] div_limit;

  assign wr_div = reg_wr && reg_addr == ADDR_DIV;
  assign wr_cmd = reg_wr && reg_addr == ADDR_CMD;

  // Detector level goes through two flip-flops before use
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      avail_s1_ff <= 1'b0;
      avail_s2_ff <= 1'b0;
    end
    else
    begin
      avail_s1_ff <= clk_avail_pin;
      avail_s2_ff <= avail_s1_ff;
    end
  end

  // Fuse levels keep sampling through reset, so the second stage has settled
  // by the time the reset values are caught after the release
  always_ff @(posedge clk_sys)
  begin
    fuse_div_s1_ff <= {div_eight_fuse, clock_pin_output_fuse, startup_fuses};
    fuse_div_s2_ff <= fuse_div_s1_ff;
    src_fuse_s1_ff <= source_select_fuses;
    src_fuse_s2_ff <= src_fuse_s1_ff;
  end

  // Unlock windows for the two protected registers
  ccrs_unlock u_div_unlock (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .arm(wr_div && reg_wdata == 8'h80),
    .consume(wr_div && !reg_wdata[UNLOCK_BIT]),
    .open_ff(div_open)
  );
  ccrs_unlock u_cmd_unlock (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .arm(wr_cmd && reg_wdata == 8'h80),
    .consume(wr_cmd && !reg_wdata[UNLOCK_BIT]),
    .open_ff(cmd_open)
  );

  // Fuse-derived reset values are caught once, after the release
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      reset_seen_ff <= 1'b0;
    end
    else
    begin
      reset_seen_ff <= 1'b1;
    end
  end

  // Trim register, factory value at reset
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rc_osc_trim_ff <= FACTORY_TRIM;
    end
    else if (reg_wr && reg_addr == ADDR_TRIM)
    begin
      rc_osc_trim_ff <= reg_wdata;
    end
  end

  // Range bit and fine value go to the analog trim one cycle behind the trim register
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      trim_range_select_ff <= FACTORY_TRIM[7];
      trim_fine_value_ff <= FACTORY_TRIM[6:0];
    end
    else
    begin
      trim_range_select_ff <= rc_osc_trim_ff[7];
      trim_fine_value_ff <= rc_osc_trim_ff[6:0];
    end
  end

  // Division field: fuse default after reset, protected writes later
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      division_select_ff <= DIV_RST_PLAIN;
    end
    else if (!reset_seen_ff)
    begin
      division_select_ff <= fuse_div_s2_ff[3] ? DIV_RST_BY8 : DIV_RST_PLAIN;
    end
    else if (wr_div && div_open && !reg_wdata[UNLOCK_BIT])
    begin
      division_select_ff <= reg_wdata[3:0];
    end
  end

  // Reserved division codes saturate at the largest legal factor
  always_comb
  begin
    if (div_target_ff > DIV_MAX_CODE)
    begin
      div_limit = 8'hFF;
    end
    else
    begin
      div_limit = 8'((9'h001 << div_target_ff) - 9'h001);
    end
  end

  // New factor is taken only at a period boundary, so no short pulse appears
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      div_cnt_ff <= 8'h00;
      div_target_ff <= 4'h0;
      sys_clk_en_ff <= 1'b0;
    end
    else if (div_cnt_ff >= div_limit)
    begin
      div_cnt_ff <= 8'h00;
      div_target_ff <= division_select_ff;
      sys_clk_en_ff <= 1'b1;
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff + 8'h01;
      sys_clk_en_ff <= 1'b0;
    end
  end

  // Command field and single-cycle request toward the clock switch
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      clock_command_code_ff <= 4'h0;
      cmd_valid_ff <= 1'b0;
      cmd_code_ff <= 4'h0;
      cmd_source_ff <= 4'h0;
      cmd_startup_ff <= 2'h0;
      cmd_clk_out_ff <= 1'b0;
    end
    else if (wr_cmd && cmd_open && !reg_wdata[UNLOCK_BIT])
    begin
      clock_command_code_ff <= reg_wdata[3:0];
      cmd_valid_ff <= !reg_wdata[3];
      cmd_code_ff <= reg_wdata[3] ? CMD_NONE : reg_wdata[3:0];
      cmd_source_ff <= source_code_field_ff;
      cmd_startup_ff <= startup_time_code_ff;
      cmd_clk_out_ff <= clock_pin_output_bit_ff;
    end
    else
    begin
      cmd_valid_ff <= 1'b0;
    end
  end

  // Ready flag: an enable or request command clears it, the detector sets it
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      source_ready_flag_ff <= 1'b0;
    end
    else if (cmd_valid_ff && (cmd_code_ff == CMD_ENABLE || cmd_code_ff == CMD_REQUEST))
    begin
      source_ready_flag_ff <= 1'b0;
    end
    else if (avail_s2_ff)
    begin
      source_ready_flag_ff <= 1'b1;
    end
  end

  // Auto-reload mode is sticky until reset
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wdog_auto_ff <= 1'b0;
    end
    else if (cmd_valid_ff && cmd_code_ff == CMD_WDOG_AUTO)
    begin
      wdog_auto_ff <= 1'b1;
    end
  end

  // Selection register: fuse defaults, software writes, recover loads source
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      clock_pin_output_bit_ff <= 1'b0;
      startup_time_code_ff <= 2'h0;
      source_code_field_ff <= 4'h0;
    end
    else if (!reset_seen_ff)
    begin
      clock_pin_output_bit_ff <= !fuse_div_s2_ff[2];
      startup_time_code_ff <= fuse_div_s2_ff[1:0];
      source_code_field_ff <= src_fuse_s2_ff;
    end
    else if (cmd_valid_ff && cmd_code_ff == CMD_RECOVER)
    begin
      source_code_field_ff <= current_source;
    end
    else if (reg_wr && reg_addr == ADDR_SEL)
    begin
      clock_pin_output_bit_ff <= reg_wdata[CLOCK_PIN_OUTPUT_BIT_BIT];
      startup_time_code_ff <= reg_wdata[5:4];
      source_code_field_ff <= reg_wdata[3:0];
    end
  end

  // Read decode, reserved bits forced to zero
  always_comb
  begin
    if (reg_addr == ADDR_TRIM)
    begin
      nxt_rdata = rc_osc_trim_ff;
    end
    else if (reg_addr == ADDR_DIV)
    begin
      nxt_rdata = {div_open, 3'h0, division_select_ff};
    end
    else if (reg_addr == ADDR_CMD)
    begin
      nxt_rdata = {cmd_open, 2'h0, source_ready_flag_ff, clock_command_code_ff};
    end
    else
    begin
      nxt_rdata = {1'b0, clock_pin_output_bit_ff, startup_time_code_ff, source_code_field_ff};
    end
  end

  // Read data stands one cycle after the strobe and only then
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      reg_rdata_ff <= 8'h00;
    end
    else
    begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  // Checks
  locked_div_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reset_seen_ff && wr_div && !div_open |=> $stable(division_select_ff))
    else $error("locked divider write changed field");
  div_unlock_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !div_open && wr_div && reg_wdata != 8'h80 |=> !div_open)
    else $error("divider unlocked by bad write");
  cmd_unlock_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !cmd_open && wr_cmd && reg_wdata == 8'h80 |=> cmd_open)
    else $error("command unlock not set");
  cmd_unlock_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(cmd_open) |-> cmd_open [*4] ##1 !cmd_open or ##[1:4] !cmd_open)
    else $error("command unlock window wrong");
  cmd_pulse_one_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cmd_valid_ff |=> !cmd_valid_ff)
    else $error("command pulse longer than one cycle");
  ready_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cmd_valid_ff && cmd_code_ff == CMD_REQUEST |=> !source_ready_flag_ff)
    else $error("ready flag not cleared");
  recover_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reset_seen_ff && cmd_valid_ff && cmd_code_ff == CMD_RECOVER
    |=> source_code_field_ff == $past(current_source))
    else $error("recover did not load source");
  wdog_sticky_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wdog_auto_ff |=> wdog_auto_ff)
    else $error("auto reload mode left without reset");
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && reg_addr == ADDR_DIV |=> reg_rdata_ff[6:4] == 3'h0)
    else $error("reserved divider bits not zero");
  div_change_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    div_open && wr_div && !reg_wdata[UNLOCK_BIT]);
  cmd_issue_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    cmd_valid_ff && cmd_code_ff == CMD_SWITCH);
  ready_set_c: cover property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(source_ready_flag_ff));
endmodule : ccrs_top

//--- verif/tb.sv
// Self-checking bench for the clock control register set
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module tb;
  import ccrs_pkg::*;
  // Trim chosen away from mid-scale so a stuck register shows
  localparam logic [7:0] TRIM_VAL = 8'h5A;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_ff;
  logic div_eight_fuse = 1'b1;
  logic clock_pin_output_fuse = 1'b0;
  logic [1:0] startup_fuses = 2'h2;
  logic [3:0] source_select_fuses = 4'hC;
  logic clk_avail_pin = 1'b0;
  logic [3:0] current_source = 4'h6;
  logic [3:0] cmd_code_ff, cmd_source_ff, division_select_ff;
  logic [1:0] cmd_startup_ff;
  logic cmd_valid_ff, cmd_clk_out_ff, wdog_auto_ff, trim_range_select_ff, sys_clk_en_ff;
  logic [6:0] trim_fine_value_ff;
  logic [7:0] v;
  int error_cnt = 0;
  int n_checks = 0;
  int pulses = 0;
  int en_cnt = 0;
  int en_gap = 0;
  int gap_run = 0;

  ccrs_top #(.FACTORY_TRIM(TRIM_VAL)) dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .div_eight_fuse, .clock_pin_output_fuse, .startup_fuses, .source_select_fuses,
    .clk_avail_pin, .current_source, .cmd_code_ff, .cmd_valid_ff, .cmd_source_ff, .cmd_startup_ff,
    .cmd_clk_out_ff, .wdog_auto_ff, .trim_range_select_ff, .trim_fine_value_ff, .division_select_ff,
    .sys_clk_en_ff);

  // 20 MHz system clock
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Counts command pulse cycles and spacing of divided clock enables
  always @(posedge clk_sys)
  begin
    if (cmd_valid_ff === 1'b1)
      pulses <= pulses + 1;
    if (sys_clk_en_ff === 1'b1)
    begin
      en_cnt <= en_cnt + 1;
      en_gap <= gap_run + 1;
      gap_run <= 0;
    end
    else
      gap_run <= gap_run + 1;
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic timeout(input string nm);
    error_cnt++;
    $display("mismatch %s expected event seen none", nm);
    summarize();
  endtask : timeout

  // Strobes are left up so back-to-back accesses need no gap
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_ff;
  endtask : rd

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // Unlock, wait gap idle cycles, then write the protected field
  // With gap zero the two writes go out back to back, nothing comes between them
  task automatic unlock_wr(input logic [1:0] a, input logic [7:0] d, input int gap);
    wr(a, 8'h80);
    if (gap > 0)
      idle(gap);
    wr(a, d);
    idle(1);
  endtask : unlock_wr

  task automatic do_reset();
    reset_n <= 1'b0;
    idle(6);
    reset_n <= 1'b1;
    idle(2);
  endtask : do_reset

  task automatic t_reset();
    for (int f = 0; f < 2; f++)
    begin
      div_eight_fuse <= f[0];
      clock_pin_output_fuse <= f[0];
      do_reset();
      `CHK("trim out", TRIM_VAL, {trim_range_select_ff, trim_fine_value_ff});
      rd(ADDR_TRIM, v);
      `CHK("trim reg", TRIM_VAL, v);
      rd(ADDR_DIV, v);
      `CHK("div reg", f ? DIV_RST_BY8 : DIV_RST_PLAIN, v);
      `CHK("div out", f ? DIV_RST_BY8 : DIV_RST_PLAIN, division_select_ff);
      rd(ADDR_SEL, v);
      `CHK("sel reg", {1'b0, ~f[0], 2'h2, 4'hC}, v);
      rd(ADDR_CMD, v);
      `CHK("cmd reg", 8'h00, v);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_trim();
    logic [7:0] t [2] = '{8'h7F, 8'h80};
    foreach (t[i])
    begin
      // No memory writes run in the bench, so the high range is safe here
      wr(ADDR_TRIM, t[i]);
      rd(ADDR_TRIM, v);
      `CHK("trim rw", t[i], v);
      `CHK("trim range", t[i][7], trim_range_select_ff);
      `CHK("trim fine", t[i][6:0], trim_fine_value_ff);
    end
    $display("test trim done");
  endtask : t_trim

  task automatic t_div();
    // Locked write, then an unlock attempt with a stray bit set
    wr(ADDR_DIV, 8'h05);
    wr(ADDR_DIV, 8'h81);
    wr(ADDR_DIV, 8'h05);
    rd(ADDR_DIV, v);
    `CHK("div locked", 8'h03, v);
    unlock_wr(ADDR_DIV, 8'h08, 3);
    rd(ADDR_DIV, v);
    `CHK("div last slot", 8'h08, v);
    unlock_wr(ADDR_DIV, 8'h02, 4);
    rd(ADDR_DIV, v);
    `CHK("div late", 8'h08, v);
    // A second unlock write neither clears nor extends the window
    wr(ADDR_DIV, 8'h80);
    unlock_wr(ADDR_DIV, 8'h01, 2);
    rd(ADDR_DIV, v);
    `CHK("div rewrite", 8'h01, v);
    wr(ADDR_DIV, 8'h80);
    idle(1);
    unlock_wr(ADDR_DIV, 8'h02, 2);
    rd(ADDR_DIV, v);
    `CHK("div no extend", 8'h01, v);
    unlock_wr(ADDR_DIV, 8'h04, 0);
    wr(ADDR_DIV, 8'h02);
    rd(ADDR_DIV, v);
    `CHK("div consumed", 8'h04, v);
    unlock_wr(ADDR_DIV, 8'h7F, 0);
    rd(ADDR_DIV, v);
    `CHK("div reserved", 8'h0F, v);
    $display("test divider done");
  endtask : t_div

  task automatic t_clk_en();
    int n0;
    for (int c = 0; c < 10; c++)
    begin
      unlock_wr(ADDR_DIV, (c == 9) ? 8'h0F : 8'(c), 0);
      n0 = en_cnt;
      for (int k = 0; k < 1500 && en_cnt < n0 + 3; k++)
        @(posedge clk_sys);
      #1;
      if (en_cnt < n0 + 3)
        timeout("clock enable");
      `CHK("enable gap", (c == 9) ? 256 : (1 << c), en_gap);
    end
    $display("test clock enable done");
  endtask : t_clk_en

  task automatic t_cmd();
    int n0;
    n0 = pulses;
    wr(ADDR_CMD, 8'h04);
    wr(ADDR_CMD, 8'h81);
    wr(ADDR_CMD, 8'h04);
    unlock_wr(ADDR_CMD, 8'h04, 4);
    idle(2);
    `CHK("locked pulses", 0, pulses - n0);
    unlock_wr(ADDR_CMD, 8'h0E, 0);
    idle(1);
    `CHK("code with bit 3", 1'b0, wdog_auto_ff);
    `CHK("none pulses", 0, pulses - n0);
    `CHK("none code", 4'h0, cmd_code_ff);
    wr(ADDR_SEL, 8'hFF);
    rd(ADDR_SEL, v);
    `CHK("sel reserved", 8'h7F, v);
    wr(ADDR_SEL, 8'h7A);
    for (int c = 1; c < 8; c++)
    begin
      n0 = pulses;
      unlock_wr(ADDR_CMD, 8'h60 | 8'(c), 0);
      idle(2);
      `CHK("pulse count", 1, pulses - n0);
      `CHK("cmd code", c, cmd_code_ff);
      // Recover rewrites the source field used by later commands
      `CHK("cmd source", (c > 5) ? 4'h6 : 4'hA, cmd_source_ff);
      `CHK("cmd startup", 2'h3, cmd_startup_ff);
      `CHK("cmd clock out", 1'b1, cmd_clk_out_ff);
      rd(ADDR_CMD, v);
      `CHK("cmd reg", c, v & 8'hEF);
    end
    rd(ADDR_SEL, v);
    `CHK("sel recovered", 8'h76, v);
    unlock_wr(ADDR_CMD, 8'h01, 0);
    `CHK("auto reload kept", 1'b1, wdog_auto_ff);
    do_reset();
    `CHK("auto reload reset", 1'b0, wdog_auto_ff);
    $display("test commands done");
  endtask : t_cmd

  task automatic t_ready();
    for (int i = 0; i < 2; i++)
    begin
      clk_avail_pin <= 1'b1;
      for (int k = 0; k < 10; k++)
      begin
        rd(ADDR_CMD, v);
        if (v[READY_BIT] === 1'b1)
          break;
      end
      `CHK("ready set", 1'b1, v[READY_BIT]);
      clk_avail_pin <= 1'b0;
      idle(4);
      unlock_wr(ADDR_CMD, {4'h0, i ? CMD_REQUEST : CMD_ENABLE}, 0);
      rd(ADDR_CMD, v);
      `CHK("ready clear", 1'b0, v[READY_BIT]);
    end
    // Switch sequence: save old source, enable new, wait ready, switch, recover, disable old
    unlock_wr(ADDR_CMD, 8'h05, 0);
    rd(ADDR_SEL, v);
    `CHK("previous source", 8'h26, v);
    wr(ADDR_SEL, 8'h29);
    unlock_wr(ADDR_CMD, 8'h02, 0);
    clk_avail_pin <= 1'b1;
    for (int k = 0; k < 10; k++)
    begin
      rd(ADDR_CMD, v);
      if (v[READY_BIT] === 1'b1)
        break;
    end
    `CHK("switch ready", 1'b1, v[READY_BIT]);
    unlock_wr(ADDR_CMD, 8'h04, 0);
    `CHK("switch target", 4'h9, cmd_source_ff);
    current_source <= 4'h9;
    unlock_wr(ADDR_CMD, 8'h05, 0);
    rd(ADDR_SEL, v);
    `CHK("switch recovered", 8'h29, v);
    wr(ADDR_SEL, 8'h26);
    unlock_wr(ADDR_CMD, 8'h01, 0);
    `CHK("old disabled", 4'h1, cmd_code_ff);
    `CHK("old source", 4'h6, cmd_source_ff);
    $display("test ready done");
  endtask : t_ready

  // Main sequence; every wait above is bounded
  initial
  begin
    do_reset();
    t_reset();
    t_trim();
    t_div();
    t_clk_en();
    t_cmd();
    t_ready();
    summarize();
  end
endmodule : tb
